// [shared/spc_defs.vh]
`ifndef SPC_DEFS_VH
`define SPC_DEFS_VH

// register byte offsets on the apb bus
`define SPC_OFF_STANDBY_SELECT_CTRL    8'h00
`define SPC_OFF_STANDBY_SELECT_CTRL3   8'h04
`define SPC_OFF_BUS_COMMON   8'h08
`define SPC_OFF_HC_PIN_CTRL  8'h0C
`define SPC_OFF_MODULE_STOP  8'h10
`define SPC_OFF_STATUS       8'h14

// standby_control_reg fields
`define SPC_BIT_STANDBY_SELECT  0
// standby_control_reg_three fields
`define SPC_BIT_GLOBAL_FLOAT    0
// bus_common_control_reg fields
`define SPC_BIT_CLOCK_DRIVE     0
`define SPC_BIT_MEMORY_DRIVE    1
`define SPC_BIT_SDRAM_DRIVE     2
// high_current_pin_control_reg fields, one per group of six pins
`define SPC_BIT_PD_LOW_KEEP     0
`define SPC_BIT_PD_HIGH_KEEP    1
`define SPC_BIT_PE_LOW_KEEP     2
`define SPC_BIT_PE_HIGH_KEEP    3
// status register fields
`define SPC_BIT_ST_RUN          0
`define SPC_BIT_ST_SLEEP        1
`define SPC_BIT_ST_SW_STANDBY   2
`define SPC_BIT_ST_EXT_BUS      3
`define SPC_POS_ST_STOPPED      8

// reset values
`define SPC_RST_STANDBY_SELECT_CTRL    1'h0
`define SPC_RST_STANDBY_SELECT_CTRL3   1'h0
`define SPC_RST_BUS_COMMON   3'h0
`define SPC_RST_HC_PIN_CTRL  4'h0

// pin counts
`define SPC_DATA_BUS_W       32
`define SPC_HC_GROUP_PINS    6
`define SPC_HC_GROUPS        4

`endif

// [core/spc_hold_cell.v]
`timescale 1ns/10ps
`include "spc_defs.vh"

// follows the live pin drive while hold is low; freezes the last
// value seen before hold rose, so the pin keeps its pre-standby state
module spc_hold_cell #(
	parameter W = 8
) (
	input  wire         pclk,
	input  wire         presetn,
	input  wire         ce,
	input  wire         hold,
	input  wire [W-1:0] live_o,
	input  wire [W-1:0] live_oe,
	output wire [W-1:0] pin_o,
	output wire [W-1:0] pin_oe
);
	reg [W-1:0] cap_o_ff;
	reg [W-1:0] cap_oe_ff;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cap_o_ff  <= {W{1'b0}};
			cap_oe_ff <= {W{1'b0}};
		end else if (ce && !hold) begin
			cap_o_ff  <= live_o;
			cap_oe_ff <= live_oe;
		end
	end

	assign pin_o  = hold ? cap_o_ff : live_o;
	assign pin_oe = hold ? cap_oe_ff : live_oe;
endmodule

// [core/spc_top.v]
// Summary of operation
// - in sleep every pin follows its still-running peripheral.
// - stopped module whose registers reset returns its pins to default.
// - stopped module keeping registers holds its pins as before stop.
// - software standby floats all 32 data bus lines unconditionally.
// - other bus groups drive when their bit is 1, float when 0.
// - clock bit covers bus clock; memory bit address strobes; control bit sdram.
// - high-current pin floats if group bit 0, float bit 1, or input.
// - high-current output keeps level when group bit 1 and float bit 0.
// - four group bits each cover six timer pins on ports d and e.
// - float bit 1 floats general pins in software standby; address-function pins follow the memory bit.
// - float bit 0 keeps outputs, floats pins set as inputs.
// - float bit 0 drives interrupt and refresh request outputs high.
// - float bit 0 keeps management data pin direction unchanged.
// - watchdog overflow holds; crystal drives go low, regardless of bits.
// - listed inputs keep receiving; others float as inputs in standby.
// - emulation mode input stays input with internal pull-up.
// - multiplexed pin standby state follows boot straps, flash enable, pin function.
// - sleep instruction enters software standby if select bit 1, else sleep.
// - module stop bit 1 gates its clock; 0 restores operation.
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/10ps
`include "spc_defs.vh"

module spc_top #(
	parameter MEM_W    = 32,
	parameter CTL_W    = 5,
	parameter GEN_W    = 16,
	parameter NMOD     = 4,
	parameter MPW      = 4,
	parameter MOD_INIT = 4'b0101
) (
	input  wire                   pclk,
	input  wire                   presetn,
	input  wire                   ce,
	input  wire                   psel,
	input  wire                   penable,
	input  wire                   pwrite,
	input  wire [7:0]             paddr,
	input  wire [31:0]            pwdata,
	output wire                   pready,
	output wire                   pslverr,
	output wire [31:0]            prdata,
	input  wire                   sleep_instr,
	input  wire                   wake_pin,
	input  wire                   boot_mode_pin_a,
	input  wire                   boot_mode_pin_b,
	input  wire                   flash_write_enable_pin,
	input  wire [GEN_W-1:0]       gen_bus_function,
	output wire [NMOD-1:0]        module_clock_en,
	input  wire [31:0]            dbus_live_o,
	input  wire [31:0]            dbus_live_oe,
	output wire [31:0]            dbus_o,
	output wire [31:0]            dbus_oe,
	input  wire                   bus_clk_live_o,
	output wire                   bus_clk_o,
	output wire                   bus_clk_oe,
	input  wire [MEM_W-1:0]       mem_live_o,
	output wire [MEM_W-1:0]       mem_o,
	output wire [MEM_W-1:0]       mem_oe,
	input  wire [CTL_W-1:0]       sdram_live_o,
	output wire [CTL_W-1:0]       sdram_o,
	output wire [CTL_W-1:0]       sdram_oe,
	input  wire [23:0]            hc_live_o,
	input  wire [23:0]            hc_live_oe,
	output wire [23:0]            hc_o,
	output wire [23:0]            hc_oe,
	input  wire [GEN_W-1:0]       gen_live_o,
	input  wire [GEN_W-1:0]       gen_live_oe,
	output wire [GEN_W-1:0]       gen_o,
	output wire [GEN_W-1:0]       gen_oe,
	input  wire                   mdio_live_o,
	input  wire                   mdio_live_oe,
	output wire                   mdio_o,
	output wire                   mdio_oe,
	input  wire                   interrupt_request_live,
	input  wire                   refresh_request_live,
	output wire                   interrupt_request_output,
	output wire                   interrupt_request_oe,
	output wire                   refresh_request_output,
	output wire                   refresh_request_oe,
	input  wire                   watchdog_live_o,
	output wire                   watchdog_overflow_output,
	input  wire                   main_crystal_live,
	input  wire                   usb_crystal_live,
	output wire                   main_crystal_drive,
	output wire                   usb_crystal_drive,
	output wire                   wake_input_en,
	output wire                   float_input_en,
	output wire                   emulation_mode_input_pullup,
	input  wire [NMOD*MPW-1:0]    mod_live_o,
	input  wire [NMOD*MPW-1:0]    mod_live_oe,
	output wire [NMOD*MPW-1:0]    mod_o,
	output wire [NMOD*MPW-1:0]    mod_oe
);
	localparam [2:0] M_RUN = 3'b001;
	localparam [2:0] M_SLP = 3'b010;
	localparam [2:0] M_SSB = 3'b100;

	// positions of each pin group inside the shared hold vector
	localparam P_CK  = 32;
	localparam P_MEM = P_CK + 1;
	localparam P_CTL = P_MEM + MEM_W;
	localparam P_HC  = P_CTL + CTL_W;
	localparam P_GEN = P_HC + 24;
	localparam P_MD  = P_GEN + GEN_W;
	localparam P_WD  = P_MD + 1;
	localparam HW    = P_WD + 1;

	reg  [2:0]      mode_ff;
	reg  [2:0]      nxt_mode;
	reg             standby_select_ff;
	reg             global_standby_float_ff;
	reg             clock_pin_standby_drive_ff;
	reg             memory_pin_standby_drive_ff;
	reg             sdram_ctrl_pin_standby_drive_ff;
	reg  [3:0]      hc_keep_ff;
	reg  [NMOD-1:0] module_stop_ff;
	reg  [31:0]     prdata_ff;
	reg  [2:0]      strap_s1_ff;
	reg  [2:0]      strap_s2_ff;
	reg             strap_done_ff;
	reg             ext_bus_ff;
	reg             wake_s1_ff;
	reg             wake_s2_ff;

	wire ssb = mode_ff[2];
	wire flt = global_standby_float_ff;

	// apb slave, zero wait states; pready drops while the clock enable is low
	wire wr_en  = psel && penable && pwrite && ce;
	wire setup  = psel && !penable && ce;
	wire hit    = (paddr == `SPC_OFF_STANDBY_SELECT_CTRL) || (paddr == `SPC_OFF_STANDBY_SELECT_CTRL3) ||
		(paddr == `SPC_OFF_BUS_COMMON) || (paddr == `SPC_OFF_HC_PIN_CTRL) ||
		(paddr == `SPC_OFF_MODULE_STOP) || (paddr == `SPC_OFF_STATUS);
	assign pready  = ce;
	assign pslverr = psel && penable && !hit;
	assign prdata  = prdata_ff;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			standby_select_ff               <= `SPC_RST_STANDBY_SELECT_CTRL;
			global_standby_float_ff         <= `SPC_RST_STANDBY_SELECT_CTRL3;
			clock_pin_standby_drive_ff      <= 1'b0;
			memory_pin_standby_drive_ff     <= 1'b0;
			sdram_ctrl_pin_standby_drive_ff <= 1'b0;
			hc_keep_ff                      <= `SPC_RST_HC_PIN_CTRL;
			module_stop_ff                  <= {NMOD{1'b0}};
		end else if (wr_en) begin
			case (paddr)
			`SPC_OFF_STANDBY_SELECT_CTRL: begin
				standby_select_ff <= pwdata[`SPC_BIT_STANDBY_SELECT];
			end
			`SPC_OFF_STANDBY_SELECT_CTRL3: begin
				global_standby_float_ff <= pwdata[`SPC_BIT_GLOBAL_FLOAT];
			end
			`SPC_OFF_BUS_COMMON: begin
				clock_pin_standby_drive_ff      <= pwdata[`SPC_BIT_CLOCK_DRIVE];
				memory_pin_standby_drive_ff     <= pwdata[`SPC_BIT_MEMORY_DRIVE];
				sdram_ctrl_pin_standby_drive_ff <= pwdata[`SPC_BIT_SDRAM_DRIVE];
			end
			`SPC_OFF_HC_PIN_CTRL: begin
				hc_keep_ff <= pwdata[3:0];
			end
			`SPC_OFF_MODULE_STOP: begin
				module_stop_ff <= pwdata[NMOD-1:0];
			end
			default: begin
			end
			endcase
		end
	end

	// read data is latched in the setup cycle so it comes from a flop
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h00000000;
		end else if (setup) begin
			prdata_ff <= 32'h00000000;
			case (paddr)
			`SPC_OFF_STANDBY_SELECT_CTRL: begin
				prdata_ff[`SPC_BIT_STANDBY_SELECT] <= standby_select_ff;
			end
			`SPC_OFF_STANDBY_SELECT_CTRL3: begin
				prdata_ff[`SPC_BIT_GLOBAL_FLOAT] <= global_standby_float_ff;
			end
			`SPC_OFF_BUS_COMMON: begin
				prdata_ff[2:0] <= {sdram_ctrl_pin_standby_drive_ff, memory_pin_standby_drive_ff,
					clock_pin_standby_drive_ff};
			end
			`SPC_OFF_HC_PIN_CTRL: begin
				prdata_ff[3:0] <= hc_keep_ff;
			end
			`SPC_OFF_MODULE_STOP: begin
				prdata_ff[NMOD-1:0] <= module_stop_ff;
			end
			`SPC_OFF_STATUS: begin
				prdata_ff[2:0] <= mode_ff;
				prdata_ff[`SPC_BIT_ST_EXT_BUS] <= ext_bus_ff;
				prdata_ff[`SPC_POS_ST_STOPPED +: NMOD] <= module_stop_ff;
			end
			default: begin
			end
			endcase
		end
	end

	// straps and the wake pin come from outside, two flops first
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_s1_ff   <= 3'h0;
			strap_s2_ff   <= 3'h0;
			strap_done_ff <= 1'b0;
			ext_bus_ff    <= 1'b0;
			wake_s1_ff    <= 1'b0;
			wake_s2_ff    <= 1'b0;
		end else if (ce) begin
			strap_s1_ff <= {flash_write_enable_pin, boot_mode_pin_b, boot_mode_pin_a};
			strap_s2_ff <= strap_s1_ff;
			wake_s1_ff  <= wake_pin;
			wake_s2_ff  <= wake_s1_ff;
			// resampled every run-mode cycle; the first, two cycles after release, sees the unfilled synchroniser
			strap_done_ff <= 1'b1;
			if (strap_done_ff == 1'b0) begin
				ext_bus_ff <= 1'b0;
			end else if (strap_done_ff && !ssb && mode_ff == M_RUN) begin
				ext_bus_ff <= !(strap_s2_ff[0] && strap_s2_ff[1]);
			end
		end
	end

	always @* begin
		nxt_mode = mode_ff;
		case (mode_ff)
		M_RUN: begin
			if (sleep_instr) begin
				nxt_mode = standby_select_ff ? M_SSB : M_SLP;
			end
		end
		M_SLP: begin
			if (wake_s2_ff) begin
				nxt_mode = M_RUN;
			end
		end
		M_SSB: begin
			if (wake_s2_ff) begin
				nxt_mode = M_RUN;
			end
		end
		default: begin
			nxt_mode = M_RUN;
		end
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_ff <= M_RUN;
		end else if (ce) begin
			mode_ff <= nxt_mode;
		end
	end

	// one hold vector for every pin that standby freezes
	wire [HW-1:0] live_o  = {watchdog_live_o, mdio_live_o, gen_live_o, hc_live_o, sdram_live_o,
		mem_live_o, bus_clk_live_o, dbus_live_o};
	wire [HW-1:0] live_oe = {1'b1, mdio_live_oe, gen_live_oe, hc_live_oe, {CTL_W{1'b1}},
		{MEM_W{1'b1}}, 1'b1, dbus_live_oe};
	wire [HW-1:0] hv_o;
	wire [HW-1:0] hv_oe;

	spc_hold_cell #(.W(HW)) u_standby_hold (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.hold    (ssb),
		.live_o  (live_o),
		.live_oe (live_oe),
		.pin_o   (hv_o),
		.pin_oe  (hv_oe)
	);

	// outside standby the cell passes live drive through, so sleep follows peripherals
	assign dbus_o     = hv_o[31:0];
	assign dbus_oe    = ssb ? 32'h00000000 : hv_oe[31:0];
	assign bus_clk_o  = hv_o[P_CK];
	assign bus_clk_oe = ssb ? clock_pin_standby_drive_ff : 1'b1;
	assign mem_o      = hv_o[P_MEM +: MEM_W];
	assign mem_oe     = {MEM_W{!ssb || memory_pin_standby_drive_ff}};
	assign sdram_o    = hv_o[P_CTL +: CTL_W];
	assign sdram_oe   = {CTL_W{!ssb || sdram_ctrl_pin_standby_drive_ff}};

	genvar i;
	generate
		for (i = 0; i < 24; i = i + 1) begin : g_hc
			wire keep = hc_keep_ff[i / `SPC_HC_GROUP_PINS];
			assign hc_o[i]  = hv_o[P_HC + i];
			// captured direction floats inputs; output level is held
			assign hc_oe[i] = ssb ? (keep && !flt && hv_oe[P_HC + i]) : hv_oe[P_HC + i];
		end
		for (i = 0; i < GEN_W; i = i + 1) begin : g_gen
			// a multiplexed pin on an address function follows the memory group bit
			wire bus_fn = gen_bus_function[i] && ext_bus_ff && !strap_s2_ff[2];
			wire sb_oe  = bus_fn ? memory_pin_standby_drive_ff : (!flt && hv_oe[P_GEN + i]);
			assign gen_o[i]  = hv_o[P_GEN + i];
			assign gen_oe[i] = ssb ? sb_oe : hv_oe[P_GEN + i];
		end
		for (i = 0; i < NMOD; i = i + 1) begin : g_mod
			wire [MPW-1:0] c_o;
			wire [MPW-1:0] c_oe;
			assign module_clock_en[i] = !module_stop_ff[i];
			spc_hold_cell #(.W(MPW)) u_mod_hold (
				.pclk    (pclk),
				.presetn (presetn),
				.ce      (ce),
				.hold    (module_stop_ff[i]),
				.live_o  (mod_live_o[i*MPW +: MPW]),
				.live_oe (mod_live_oe[i*MPW +: MPW]),
				.pin_o   (c_o),
				.pin_oe  (c_oe)
			);
			// default state: released input with output low
			assign mod_o[i*MPW +: MPW]  = (module_stop_ff[i] && MOD_INIT[i]) ? {MPW{1'b0}} : c_o;
			assign mod_oe[i*MPW +: MPW] = (module_stop_ff[i] && MOD_INIT[i]) ? {MPW{1'b0}} : c_oe;
		end
	endgenerate

	assign mdio_o  = hv_o[P_MD];
	assign mdio_oe = ssb ? (!flt && hv_oe[P_MD]) : hv_oe[P_MD];

	assign interrupt_request_output = ssb ? 1'b1 : interrupt_request_live;
	assign interrupt_request_oe     = !(ssb && flt);
	assign refresh_request_output   = ssb ? 1'b1 : refresh_request_live;
	assign refresh_request_oe       = !(ssb && flt);

	assign watchdog_overflow_output = hv_o[P_WD];
	assign main_crystal_drive       = ssb ? 1'b0 : main_crystal_live;
	assign usb_crystal_drive        = ssb ? 1'b0 : usb_crystal_live;

	// wake sources stay live; bus-grant, data, serial and analog inputs are gated
	assign wake_input_en               = 1'b1;
	assign float_input_en              = !ssb;
	assign emulation_mode_input_pullup = 1'b1;
endmodule

// [dv/spc_board_model.sv]
`timescale 1ns/10ps
// board side of the data bus; released lines wander, so a floating pad never reads back its old value
module spc_board_model (
	input  wire        pclk,
	input  wire [31:0] dbus_o,
	input  wire [31:0] dbus_oe,
	output wire [31:0] dbus_wire
);
	reg [31:0] last_ff = 32'h0;
	always @(posedge pclk) begin
		last_ff <= dbus_wire;
	end
	assign dbus_wire = (dbus_o & dbus_oe) | (~last_ff & ~dbus_oe);
endmodule

// [dv/spc_top_sva.sv]
`timescale 1ns/10ps
module spc_top_sva #(
	parameter MEM_W = 32,
	parameter NMOD  = 4
) (
	input wire             pclk,
	input wire             presetn,
	input wire             ce,
	input wire             psel,
	input wire             penable,
	input wire             pwrite,
	input wire [7:0]       paddr,
	input wire [31:0]      pwdata,
	input wire [NMOD-1:0]  module_clock_en,
	input wire [31:0]      dbus_oe,
	input wire             bus_clk_oe,
	input wire [MEM_W-1:0] mem_oe,
	input wire [23:0]      hc_live_o,
	input wire [23:0]      hc_live_oe,
	input wire [23:0]      hc_o,
	input wire [23:0]      hc_oe,
	input wire             float_input_en,
	input wire             interrupt_request_output,
	input wire             main_crystal_drive,
	input wire             usb_crystal_drive
);
	// shadow copies of the control bits, taken at the same write edge as the block
	reg [2:0]      bus_ff;
	reg            float_ff;
	reg [3:0]      keep_ff;
	reg [NMOD-1:0] stop_ff;
	wire           wr = psel && penable && pwrite && ce;
	wire           standby_select = !float_input_en;
	wire [23:0]    mask = {{6{keep_ff[3]}}, {6{keep_ff[2]}}, {6{keep_ff[1]}}, {6{keep_ff[0]}}};
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_ff <= 3'h0;
			float_ff <= 1'b0;
			keep_ff <= 4'h0;
			stop_ff <= {NMOD{1'b0}};
		end else if (wr) begin
			if (paddr == 8'h04) float_ff <= pwdata[0];
			if (paddr == 8'h08) bus_ff <= pwdata[2:0];
			if (paddr == 8'h0C) keep_ff <= pwdata[3:0];
			if (paddr == 8'h10) stop_ff <= pwdata[NMOD-1:0];
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_dbus_float: assert property (standby_select |-> dbus_oe == 32'h0)
		else $error("data bus driven in standby");
	a_clk_group: assert property (standby_select |-> bus_clk_oe == bus_ff[0])
		else $error("bus clock drive wrong in standby");
	a_mem_group: assert property (standby_select |-> mem_oe == {MEM_W{bus_ff[1]}})
		else $error("memory pins drive wrong in standby");
	a_hc_group: assert property (standby_select |-> (hc_oe & ~mask) == 24'h0)
		else $error("high current pin driven without its group bit");
	a_hc_follow: assert property (float_input_en |-> hc_o == hc_live_o && hc_oe == hc_live_oe)
		else $error("high current pins not following live drive");
	a_irq_high: assert property (standby_select && !float_ff |-> interrupt_request_output)
		else $error("interrupt request output not high in standby");
	a_crystal_low: assert property (standby_select |-> !main_crystal_drive && !usb_crystal_drive)
		else $error("crystal drive not low in standby");
	a_mod_clock: assert property (wr && paddr == 8'h10 |=> module_clock_en == ~stop_ff)
		else $error("module clock enable not following stop bits");
	c_standby: cover property ($fell(float_input_en));
	c_float: cover property (standby_select && float_ff);
	c_stop: cover property (module_clock_en != {NMOD{1'b1}});
endmodule

bind spc_top spc_top_sva #(.MEM_W(MEM_W), .NMOD(NMOD)) u_sva (
	.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .module_clock_en(module_clock_en), .dbus_oe(dbus_oe),
	.bus_clk_oe(bus_clk_oe), .mem_oe(mem_oe), .hc_live_o(hc_live_o), .hc_live_oe(hc_live_oe),
	.hc_o(hc_o), .hc_oe(hc_oe), .float_input_en(float_input_en),
	.interrupt_request_output(interrupt_request_output), .main_crystal_drive(main_crystal_drive),
	.usb_crystal_drive(usb_crystal_drive)
);

// [dv/spc_top_tb.sv]
`timescale 1ns/10ps
module spc_top_tb;
	reg pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	reg [7:0] paddr = 8'h00;
	reg [31:0] pwdata = 32'h0, dbus_live_o = 32'h0, dbus_live_oe = 32'h0, mem_live_o = 32'h0, rd;
	reg sleep_instr = 1'b0, wake_pin = 1'b0, boot_mode_pin_a = 1'b0, boot_mode_pin_b = 1'b0;
	reg flash_write_enable_pin = 1'b0, bus_clk_live_o = 1'b0, mdio_live_o = 1'b0, mdio_live_oe = 1'b0;
	reg interrupt_request_live = 1'b0, refresh_request_live = 1'b0, watchdog_live_o = 1'b0, err;
	reg main_crystal_live = 1'b0, usb_crystal_live = 1'b0;
	reg [15:0] gen_bus_function = 16'h0, gen_live_o = 16'h0, gen_live_oe = 16'h0;
	reg [15:0] mod_live_o = 16'h0, mod_live_oe = 16'h0;
	reg [4:0] sdram_live_o = 5'h0;
	reg [23:0] hc_live_o = 24'h0, hc_live_oe = 24'h0;
	wire pready, pslverr, bus_clk_o, bus_clk_oe, mdio_o, mdio_oe, interrupt_request_output;
	wire interrupt_request_oe, refresh_request_output, refresh_request_oe, watchdog_overflow_output;
	wire main_crystal_drive, usb_crystal_drive, wake_input_en, float_input_en, emulation_mode_input_pullup;
	wire [31:0] prdata, dbus_o, dbus_oe, mem_o, mem_oe, dbus_wire;
	wire [3:0] module_clock_en;
	wire [4:0] sdram_o, sdram_oe;
	wire [23:0] hc_o, hc_oe;
	wire [15:0] gen_o, gen_oe, mod_o, mod_oe;
	integer bad_count = 0, num_checks = 0;
	localparam [3:0] MINIT = 4'b0101;
	always #20 pclk = ~pclk;
	spc_top #(.MOD_INIT(MINIT)) uut (.*);
	spc_board_model board (.pclk(pclk), .dbus_o(dbus_o), .dbus_oe(dbus_oe), .dbus_wire(dbus_wire));
	task wrap_up;
		begin
			$display("checks %0d mismatches %0d", num_checks, bad_count);
			if (bad_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
			else $display("TESTS FAILED");
			$finish;
		end
	endtask
	task chk(input string name, input [31:0] seen, input [31:0] exp);
		begin
			num_checks = num_checks + 1;
			if (seen !== exp) begin
				bad_count = bad_count + 1;
				$display("wrong value %s expected %h seen %h", name, exp, seen);
			end
		end
	endtask
	// pready is sampled, never assumed; a stuck slave ends the run
	task apb(input w, input [7:0] a, input [31:0] d);
		integer n;
		begin
			@(posedge pclk);
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			n = 0;
			@(posedge pclk);
			while (pready !== 1'b1 && n < 20) begin
				n = n + 1;
				@(posedge pclk);
			end
			if (n == 20) begin
				bad_count = bad_count + 1;
				wrap_up;
			end
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task sleep_wake(input phase);
		begin
			@(posedge pclk);
			if (phase) sleep_instr <= 1'b1;
			else wake_pin <= 1'b1;
			repeat (phase ? 1 : 4) @(posedge pclk);
			sleep_instr <= 1'b0;
			wake_pin <= 1'b0;
			#5;
		end
	endtask
	task t_reset;
		integer i;
		begin
			for (i = 0; i < 5; i = i + 1) begin
				apb(1'b0, {i[5:0], 2'b00}, 32'h0);
				chk("reg", rd, 32'h0);
			end
			apb(1'b0, 8'h14, 32'h0);
			chk("status", rd, 32'h9);
			apb(1'b1, 8'h40, 32'hFFFFFFFF);
			apb(1'b0, 8'h40, 32'h0);
			chk("unmapped", {rd[30:0], err}, 32'h1);
		end
	endtask
	task t_sleep;
		begin
			apb(1'b1, 8'h00, 32'h0);
			sleep_wake(1'b1);
			@(posedge pclk);
			hc_live_o <= 24'h5A5A5A;
			#5;
			chk("sleep pins", hc_o, 24'h5A5A5A);
			apb(1'b0, 8'h14, 32'h0);
			chk("sleep mode", rd, 32'hA);
			sleep_wake(1'b0);
			apb(1'b0, 8'h14, 32'h0);
			chk("woken", rd, 32'h9);
		end
	endtask
	task t_standby(input flt, input [2:0] bus, input [3:0] keep);
		reg [23:0] hexp;
		begin
			apb(1'b1, 8'h04, {31'h0, flt});
			apb(1'b1, 8'h08, {29'h0, bus});
			apb(1'b1, 8'h0C, {28'h0, keep});
			apb(1'b1, 8'h00, 32'h1);
			hc_live_o <= 24'hA5A5A5;
			hc_live_oe <= 24'hFFFF0F;
			// low byte of the general pins carries an address function
			gen_bus_function <= 16'h00FF;
			{gen_live_o, gen_live_oe, mdio_live_o, mdio_live_oe} <= {32'h3C5A0FF0, 2'b11};
			{watchdog_live_o, main_crystal_live, usb_crystal_live, bus_clk_live_o} <= 4'hF;
			{dbus_live_o, dbus_live_oe, mem_live_o, sdram_live_o} <= {96'h0FFFFFFFF0, 5'h1F};
			sleep_wake(1'b1);
			@(posedge pclk);
			{hc_live_o, hc_live_oe, gen_live_o, gen_live_oe} <= {24'h5A5A5A, 24'h0, 32'hC3A50000};
			{mdio_live_o, mdio_live_oe, watchdog_live_o, bus_clk_live_o, sdram_live_o, mem_live_o} <= 41'h0;
			#5;
			hexp = flt ? 24'h0 : 24'hFFFF0F & {{6{keep[3]}}, {6{keep[2]}}, {6{keep[1]}}, {6{keep[0]}}};
			chk("dbus oe", dbus_oe, 32'h0);
			chk("clk oe", bus_clk_oe, bus[0]);
			chk("mem ctl oe", {&mem_oe, |mem_oe, &sdram_oe, |sdram_oe}, {{2{bus[1]}}, {2{bus[2]}}});
			chk("held", {bus_clk_o, mdio_o, sdram_o, mem_o[24:0]}, {2'b11, 5'h1F, 25'h1FFFFF0});
			chk("hc oe", hc_oe, hexp);
			chk("hc o", hc_o & hexp, 24'hA5A5A5 & hexp);
			chk("gen", {gen_oe, gen_o & gen_oe}, flt ? 32'h00FF005A : 32'h0F000C00);
			chk("req out", {interrupt_request_output, refresh_request_output}, 2'b11);
			chk("req oe", {interrupt_request_oe, refresh_request_oe}, {!flt, !flt});
			chk("mdio oe", mdio_oe, !flt);
			chk("fixed", {watchdog_overflow_output, main_crystal_drive, usb_crystal_drive}, 3'b100);
			chk("inputs", {wake_input_en, float_input_en, emulation_mode_input_pullup}, 3'b101);
			// a released pad wanders on the board, so it must not repeat its last level
			rd = dbus_wire;
			@(posedge pclk);
			#5;
			chk("dbus pad", dbus_wire, ~rd);
			sleep_wake(1'b0);
			chk("restored", hc_o, 24'h5A5A5A);
			apb(1'b1, 8'h00, 32'h0);
		end
	endtask
	task t_modstop;
		integer m;
		reg [15:0] e;
		begin
			mod_live_o <= 16'hFFFF;
			mod_live_oe <= 16'hFFFF;
			apb(1'b1, 8'h10, 32'h3);
			{mod_live_o, mod_live_oe} <= 32'h0;
			#5;
			for (m = 0; m < 4; m = m + 1) e[m*4 +: 4] = (m < 2 && !MINIT[m]) ? 4'hF : 4'h0;
			chk("clock en", module_clock_en, 4'hC);
			chk("mod pins", {mod_o, mod_oe}, {e, e});
			apb(1'b1, 8'h10, 32'h0);
			mod_live_o <= 16'h1234;
			@(posedge pclk);
			#5;
			chk("mod run", {module_clock_en, mod_o}, 20'hF1234);
		end
	endtask
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		t_reset;
		t_sleep;
		t_standby(1'b0, 3'b101, 4'b0101);
		t_standby(1'b1, 3'b010, 4'b1010);
		t_modstop;
		wrap_up;
	end
endmodule
